// file: src/pbp_pkg.sv
// shared constants and types for the pseudo-static ram bus port
package pbp_pkg;
   localparam int          CLK_PERIOD_NS   = 4;
   localparam int          INIT_TIME_US    = 150;
   localparam int          INIT_CYCLES_DEF = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] BCR_DEFAULT     = 16'h1D1F;
   localparam logic [15:0] RCR_DEFAULT     = 16'h0000;
   // bus config field positions
   localparam int          BCR_MODE_BIT    = 15;
   localparam int          BCR_LTYPE_BIT   = 14;
   localparam int          BCR_LAT_LSB     = 11;
   localparam int          BCR_WPOL_BIT    = 10;
   localparam int          BCR_WRAP_BIT    = 3;
   localparam int          BCR_BL_LSB      = 0;
   localparam logic [2:0]  BL_4            = 3'h1;
   localparam logic [2:0]  BL_8            = 3'h2;
   localparam logic [2:0]  BL_16           = 3'h3;
   localparam logic [2:0]  LAT_CODE_9      = 3'h0;
   localparam logic [3:0]  LAT_CYC_9       = 4'h9;
   localparam logic [3:0]  LAT_CYC_DEF     = 4'h4;
   // synchronised pin vector positions
   localparam int          P_CLK           = 6;
   localparam int          P_CE            = 5;
   localparam int          P_ADV           = 4;
   localparam int          P_OE            = 3;
   localparam int          P_WE            = 2;
   localparam int          P_UB            = 1;
   localparam int          P_LB            = 0;
   typedef enum logic [5:0] {
      ST_INIT  = 6'h01,
      ST_IDLE  = 6'h02,
      ST_LAT   = 6'h04,
      ST_DATA  = 6'h08,
      ST_DONE  = 6'h10,
      ST_ASYNC = 6'h20
   } pbp_state_e;
endpackage : pbp_pkg

// file: src/pbp_fifo_if.sv
// valid/ready carrier between the port logic and its write buffer
`timescale 1ns/1ns
`default_nettype none
interface pbp_fifo_if #(parameter int W = 32);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : pbp_fifo_if
`default_nettype wire

// file: src/pbp_fifo.sv
// write buffer fifo, power-of-two depth
`timescale 1ns/1ns
`default_nettype none
module pbp_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic en_i,
   pbp_fifo_if.fifo  f
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW:0] wp;
      logic [PW:0] rp;
   } pbp_fifo_s;
   pbp_fifo_s    r;
   pbp_fifo_s    n;
   logic [W-1:0] mem [DEPTH];
   logic         full;
   logic         push;
   logic         pop;

   assign full        = (r.wp[PW] != r.rp[PW]) && (r.wp[PW-1:0] == r.rp[PW-1:0]);
   assign f.in_ready  = ~full;
   assign f.out_valid = (r.wp != r.rp);
   assign f.out_data  = mem[r.rp[PW-1:0]];
   assign push        = f.in_valid & ~full;
   assign pop         = f.out_valid & f.out_ready;

   always_comb begin
      n = r;
      if (push) begin
         n.wp = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else if (en_i) begin
         r <= n;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (en_i && push) begin
         mem[r.wp[PW-1:0]] <= f.in_data;
      end
   end
endmodule : pbp_fifo
`default_nettype wire

// file: src/pbp_top.sv
// device-side bus port of a burst pseudo-static ram with muxed address/data
// Overview of operation
// RULE1: after supplies settle, wait 150 us loading config defaults before operating.
// RULE2: controller keeps chip select high throughout the power-up interval.
// RULE3: fixed bursts move exactly 4, 8 or 16 words per config.
// RULE4: continuous burst runs from latched address to the row end.
// RULE5: latency count sets cycles before first word; fixed or variable read latency.
// RULE6: variable latency read hitting refresh keeps wait active until refresh ends.
// RULE7: fixed latency delivers first word after worst case, refresh included.
// RULE8: controller ignoring wait stops bursts at row boundaries itself.
// RULE9: wait active at burst start, inactive for data, active again at row end.
// RULE10: suspend by stopping clock low; device keeps driving wait.
// RULE11: resume by lowering output enable, then restarting the clock.
// RULE12: controller never holds select low beyond the maximum select low time.
// RULE13: first clock rise with address valid low latches address and write enable.
// RULE14: after wait goes inactive, words move on successive clock rises.
// RULE15: controller keeps select low until the first word is valid.
// RULE16: async read: latch address on address valid rise, then lower output enable.
// RULE17: async write data latched on first rise of select, write or byte enables; code needs both byte enables low before, else never latches.
// RULE18: async operations keep clock low and write enable within time limit.
// RULE19: wait driven meaninglessly in async reads, released in async writes.
// RULE20: sync configuration still accepts async reads and writes with clock low.
// RULE21: disabled bytes are neither written nor driven.
// RULE22: standby while select is high; reduced power after completion or static inputs.
// RULE23: mode bit clear selects sync burst, set selects async only.
// RULE24: latency code 000 is 9 cycles, 010..110 are 3..7, default 4.
// RULE25: wait polarity bit clear makes wait active low, set active high.
// RULE26: word address advances by one per transferred burst word.
`timescale 1ns/1ns
`default_nettype none
module pbp_top import pbp_pkg::*; #(
   parameter int          ADDR_W         = 21,
   parameter int          MEM_AW         = 12,
   parameter int          ROW_WORDS      = 128,
   parameter int          FIFO_DEPTH     = 16,
   parameter logic [7:0]  REFRESH_CYCLES = 8'h08,
   parameter logic [7:0]  IDLE_CYCLES    = 8'h40,
   parameter int unsigned INIT_CYCLES    = INIT_CYCLES_DEF
) (
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   input  wire logic              en_i,
   input  wire logic              mem_clk_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              address_valid_n_i,
   input  wire logic              output_enable_n_i,
   input  wire logic              write_enable_n_i,
   input  wire logic              upper_byte_enable_n_i,
   input  wire logic              lower_byte_enable_n_i,
   input  wire logic [15:0]       muxed_addr_data_bus_i,
   input  wire logic [ADDR_W-17:0] addr_hi_i,
   output logic      [15:0]       muxed_addr_data_bus_o,
   output logic      [1:0]        muxed_addr_data_bus_oe_n_o,
   output logic                   wait_o,
   output logic                   wait_oe_n_o,
   input  wire logic              refresh_req_i,
   input  wire logic              cfg_write_i,
   input  wire logic [15:0]       cfg_bus_config_i,
   input  wire logic [15:0]       cfg_refresh_config_i,
   output logic      [15:0]       bus_config_reg_o,
   output logic      [15:0]       refresh_config_reg_o,
   output logic                   init_done_o,
   output logic                   standby_o,
   output logic                   low_power_o
);
   localparam int HW = ADDR_W - 16;
   localparam int RW = $clog2(ROW_WORDS);
   localparam int FW = MEM_AW + 18;

   typedef struct packed {
      pbp_state_e        st;
      logic [6:0]        pin1;
      logic [6:0]        pin2;
      logic [6:0]        pin3;
      logic [15:0]       dq1;
      logic [15:0]       dq2;
      logic [15:0]       dq3;
      logic [HW-1:0]     ah1;
      logic [HW-1:0]     ah2;
      logic [15:0]       init_cnt;
      logic [15:0]       bus_config_reg;
      logic [15:0]       refresh_config_reg;
      logic [ADDR_W-1:0] addr;
      logic [3:0]        lat_cnt;
      logic [8:0]        words;
      logic              wr;
      logic [15:0]       dout;
      logic [7:0]        ref_cnt;
      logic              ref_pend;
      logic [7:0]        idle_cnt;
      logic              lowpwr;
   } pbp_state_s;

   pbp_state_s        r;
   pbp_state_s        n;
   logic [15:0]       mem [2**MEM_AW];
   logic              clk_rise, adv_rise, adv_fall, ce_lo, wg_rise;
   logic              async_mode, fixed, pol, wrap, cont, ref_busy, rd_ok, lat_ok, hold_ref;
   logic              row_end, last, wait_act, rd_drive;
   logic [8:0]        len;
   logic [ADDR_W-1:0] nxt;
   logic [15:0]       wdata;

   pbp_fifo_if #(.W(FW)) ff ();

   pbp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wbuf (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (en_i),
      .f         (ff)
   );

   function automatic logic [3:0] lat_of(input logic [2:0] c);
      case (c)
         LAT_CODE_9:                              lat_of = LAT_CYC_9;
         3'h2, 3'h3, 3'h4, 3'h5, 3'h6:            lat_of = {1'b0, c} + 4'h1;
         default:                                 lat_of = LAT_CYC_DEF; // reserved codes
      endcase
   endfunction : lat_of

   assign clk_rise   = r.pin2[P_CLK] & ~r.pin3[P_CLK];
   assign adv_rise   = r.pin2[P_ADV] & ~r.pin3[P_ADV];
   assign adv_fall   = ~r.pin2[P_ADV] & r.pin3[P_ADV];
   assign ce_lo      = ~r.pin2[P_CE];
   // a rise of select, write or a byte enable, with all four low the cycle before, ends an async write
   assign wg_rise    = (|{r.pin2[P_CE], r.pin2[P_WE], r.pin2[P_UB], r.pin2[P_LB]}) &
                       ~(|{r.pin3[P_CE], r.pin3[P_WE], r.pin3[P_UB], r.pin3[P_LB]}); // [RULE17]
   assign async_mode = r.bus_config_reg[BCR_MODE_BIT]; // [RULE23]
   assign fixed      = r.bus_config_reg[BCR_LTYPE_BIT];
   assign pol        = r.bus_config_reg[BCR_WPOL_BIT];
   assign wrap       = ~r.bus_config_reg[BCR_WRAP_BIT];
   assign ref_busy   = (r.ref_cnt != 8'h00);
   assign rd_ok      = ~ref_busy & ~ff.out_valid;
   assign lat_ok     = r.wr ? ff.in_ready : (fixed | rd_ok); // [RULE6] [RULE7]
   // fixed latency reads defer refresh so the count always covers it
   assign hold_ref   = fixed & ~r.wr & (r.st == ST_LAT || r.st == ST_DATA); // [RULE7]
   assign row_end    = &r.addr[RW-1:0];

   always_comb begin
      cont = 1'b0;
      case (r.bus_config_reg[BCR_BL_LSB +: 3])
         BL_4:    len = 9'h003; // [RULE3]
         BL_8:    len = 9'h007;
         BL_16:   len = 9'h00F;
         default: begin
            len  = 9'h000;
            cont = 1'b1; // [RULE4]
         end
      endcase
   end

   // wrap inside an aligned block for fixed bursts with wrap enabled, else plain increment
   assign nxt  = (~cont & wrap) ? ((r.addr & ~ADDR_W'(len)) | ((r.addr + 1'b1) & ADDR_W'(len)))
                                : r.addr + 1'b1; // [RULE26]
   assign last = ~cont & (r.words == len); // [RULE3]

   always_comb begin
      n              = r;
      ff.in_valid    = 1'b0;
      ff.in_data     = '0;
      n.pin1         = {mem_clk_i, chip_select_n_i, address_valid_n_i, output_enable_n_i,
                        write_enable_n_i, upper_byte_enable_n_i, lower_byte_enable_n_i};
      n.pin2         = r.pin1;
      n.pin3         = r.pin2;
      n.dq1          = muxed_addr_data_bus_i;
      n.dq2          = r.dq1;
      n.dq3          = r.dq2;
      n.ah1          = addr_hi_i;
      n.ah2          = r.ah1;
      if (r.ref_pend && !ref_busy && !hold_ref && r.st != ST_INIT) begin
         n.ref_pend = 1'b0;
         n.ref_cnt  = REFRESH_CYCLES;
      end else if (ref_busy) begin
         n.ref_cnt  = r.ref_cnt - 8'h01;
      end
      if (refresh_req_i) begin
         n.ref_pend = 1'b1;
      end
      if (cfg_write_i && r.st != ST_INIT && !ce_lo) begin
         n.bus_config_reg = cfg_bus_config_i;
         n.refresh_config_reg = cfg_refresh_config_i;
      end
      if (r.pin2 != r.pin3 || r.dq2 != r.dq3) begin
         n.idle_cnt = 8'h00;
         n.lowpwr   = 1'b0; // [RULE22]
      end else if (r.idle_cnt != IDLE_CYCLES) begin
         n.idle_cnt = r.idle_cnt + 8'h01;
      end else begin
         n.lowpwr   = 1'b1;
      end
      case (r.st)
         ST_INIT: begin
            // pins are ignored until the defaults are in
            if (r.init_cnt == 16'h0000) begin
               n.bus_config_reg = BCR_DEFAULT; // [RULE1] [RULE2]
               n.refresh_config_reg = RCR_DEFAULT;
               n.st  = ST_IDLE;
            end else begin
               n.init_cnt = r.init_cnt - 16'h0001;
            end
         end
         ST_IDLE: begin
            if (ce_lo && !async_mode && clk_rise && !r.pin2[P_ADV]) begin
               n.addr    = {r.ah2, r.dq2}; // [RULE13]
               n.wr      = ~r.pin2[P_WE];
               n.lat_cnt = lat_of(r.bus_config_reg[BCR_LAT_LSB +: 3]) - 4'h1; // [RULE5] [RULE24]
               n.words   = 9'h000;
               n.st      = ST_LAT;
            end else if (ce_lo && adv_rise && !r.pin2[P_CLK]) begin
               n.addr = {r.ah2, r.dq3}; // [RULE16] [RULE20]
               n.wr   = ~r.pin2[P_WE];
               n.st   = ST_ASYNC;
            end
         end
         ST_LAT: begin
            // a stopped clock simply freezes the count
            if (clk_rise) begin
               if (r.lat_cnt > 4'h1) begin
                  n.lat_cnt = r.lat_cnt - 4'h1; // [RULE5]
               end else if (lat_ok) begin
                  n.st   = ST_DATA; // [RULE6]
                  n.dout = mem[r.addr[MEM_AW-1:0]];
               end
            end
         end
         ST_DATA: begin
            if (clk_rise && (!r.wr || ff.in_ready)) begin
               if (r.wr) begin
                  ff.in_valid = 1'b1; // [RULE14]
                  ff.in_data  = {r.addr[MEM_AW-1:0], ~r.pin2[P_UB], ~r.pin2[P_LB], r.dq2}; // [RULE21]
               end
               n.addr  = nxt; // [RULE26]
               n.dout  = mem[nxt[MEM_AW-1:0]]; // [RULE14]
               n.words = r.words + 9'h001;
               if (last || (row_end && (cont || !wrap))) begin
                  n.st     = ST_DONE; // [RULE3] [RULE4] [RULE9]
                  n.lowpwr = 1'b1; // [RULE22]
               end
            end
         end
         ST_DONE: begin
            n.st = ST_DONE;
         end
         ST_ASYNC: begin
            if (!r.wr && !r.pin2[P_OE] && rd_ok) begin
               n.dout = mem[r.addr[MEM_AW-1:0]]; // [RULE16]
            end
            if (r.wr && wg_rise) begin
               ff.in_valid = 1'b1; // [RULE17]
               ff.in_data  = {r.addr[MEM_AW-1:0], ~r.pin3[P_UB], ~r.pin3[P_LB], r.dq3}; // [RULE21]
            end
            if (adv_fall) begin
               n.st = ST_IDLE; // [RULE20]
            end
         end
         default: n.st = ST_IDLE;
      endcase
      if (!ce_lo && r.st != ST_INIT) begin
         n.st = ST_IDLE; // [RULE22]
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r          <= '0;
         r.st       <= ST_INIT;
         r.init_cnt <= 16'(INIT_CYCLES - 1);
      end else if (en_i) begin
         r <= n;
      end
   end

   // buffer drains to the array whenever refresh leaves it free
   assign ff.out_ready = ~ref_busy;

   for (genvar g = 0; g < 2; g++) begin : g_byte
      assign wdata[8*g +: 8] = ff.out_data[16+g] ? ff.out_data[8*g +: 8]
                                                 : mem[ff.out_data[FW-1 -: MEM_AW]][8*g +: 8]; // [RULE21]
   end

   always_ff @(posedge clk_sys_i) begin
      if (en_i && ff.out_valid && ff.out_ready) begin
         mem[ff.out_data[FW-1 -: MEM_AW]] <= wdata;
      end
   end

   assign wait_act = (r.st == ST_LAT) || (r.st == ST_DONE) ||
                     (r.st == ST_DATA && r.wr && !ff.in_ready) || (r.st == ST_ASYNC && !r.wr); // [RULE9] [RULE10]
   assign wait_o   = pol ? wait_act : ~wait_act; // [RULE25]
   assign wait_oe_n_o = ~(ce_lo && r.st != ST_INIT && !(r.st == ST_ASYNC && r.wr)); // [RULE19]
   assign rd_drive = ce_lo && !r.pin2[P_OE] && !r.wr && (r.st == ST_DATA || r.st == ST_ASYNC); // [RULE11]
   assign muxed_addr_data_bus_oe_n_o = ~({2{rd_drive}} & ~{r.pin2[P_UB], r.pin2[P_LB]}); // [RULE21]
   assign muxed_addr_data_bus_o = r.dout;
   assign bus_config_reg_o      = r.bus_config_reg;
   assign refresh_config_reg_o  = r.refresh_config_reg;
   assign init_done_o           = (r.st != ST_INIT);
   assign standby_o             = init_done_o && !ce_lo; // [RULE22]
   assign low_power_o           = r.lowpwr | standby_o;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   a_init_quiet: assert property (r.st == ST_INIT |-> wait_oe_n_o && muxed_addr_data_bus_oe_n_o == 2'h3) // [RULE1]
      else $error("bus driven during init");
   a_init_hold: assert property (en_i && r.st == ST_INIT && r.init_cnt != 16'h0000 |=> r.st == ST_INIT) // [RULE1]
      else $error("init left early");
   a_burst_latch: assert property (en_i && r.st == ST_IDLE && ce_lo && !async_mode && clk_rise && // [RULE13]
                                   !r.pin2[P_ADV] |=> r.st == ST_LAT && r.wr == !$past(r.pin2[P_WE]))
      else $error("burst not latched");
   a_async_only: assert property (en_i && async_mode && r.st == ST_IDLE |=> r.st != ST_LAT) // [RULE23]
      else $error("burst started in async mode");
   a_var_refresh: assert property (en_i && r.st == ST_LAT && !r.wr && !fixed && ref_busy // [RULE6]
                                   |=> r.st != ST_DATA)
      else $error("read data during refresh");
   a_fixed_noref: assert property (en_i && hold_ref && !ref_busy |=> !ref_busy) // [RULE7]
      else $error("refresh began in fixed read");
   a_burst_len: assert property (en_i && r.st == ST_DATA && clk_rise && ce_lo && last && !r.wr // [RULE3]
                                 |=> r.st == ST_DONE)
      else $error("burst length wrong");
   a_addr_step: assert property (en_i && r.st == ST_DATA && clk_rise && ce_lo && !r.wr && (cont || !wrap) // [RULE26]
                                 |=> r.addr == ADDR_W'($past(r.addr) + 1'b1))
      else $error("address did not step");
   a_wait_data: assert property (r.st == ST_DATA && !r.wr && !wait_oe_n_o |-> wait_o == !pol) // [RULE25]
      else $error("wait level wrong in data");
   a_async_hiz: assert property (r.st == ST_ASYNC && r.wr |-> wait_oe_n_o) // [RULE19]
      else $error("wait driven in async write");
   a_standby: assert property (en_i && r.st != ST_INIT && r.pin2[P_CE] |-> standby_o ##1 r.st == ST_IDLE) // [RULE22]
      else $error("no standby on deselect");

   c_read_done:  cover property (r.st == ST_DATA && !r.wr ##1 r.st == ST_DONE);
   c_write_push: cover property (r.st == ST_DATA && ff.in_valid);
   c_ref_stall:  cover property (r.st == ST_LAT && !fixed && ref_busy);
   c_async_wr:   cover property (r.st == ST_ASYNC && ff.in_valid);
endmodule : pbp_top
`default_nettype wire

// file: verif/pbp_ctl_model.sv
// controller-side model of the burst bus: drives the pins, samples wait and data
`timescale 1ns/1ns
`default_nettype none
module pbp_ctl_model import pbp_pkg::*; #(
   parameter int HP = 5
) (
   input  wire logic        clk_sys_i,
   input  wire logic        wait_i,
   input  wire logic        wait_oe_n_i,
   input  wire logic [15:0] dev_dq_i,
   input  wire logic [1:0]  dev_oe_n_i,
   output logic      [6:0]  pins_o,
   output logic      [15:0] dq_o
);
   logic [15:0] wq[16], rq[16];
   logic [15:0] dq_d = 16'h0000, last = 16'h0000;
   logic        drv = 1'b0, wpol = 1'b1, susp_oe, aoe, idle_w;
   int          susp = 0;
   // select high from time zero on, so init is never disturbed
   initial pins_o = 7'h3F;
   // a released lane toggles, so a stale word never passes for read data
   assign dq_o[15:8] = drv ? dq_d[15:8] : (dev_oe_n_i[1] ? ~last[15:8] : dev_dq_i[15:8]);
   assign dq_o[7:0]  = drv ? dq_d[7:0] : (dev_oe_n_i[0] ? ~last[7:0] : dev_dq_i[7:0]);
   always @(posedge clk_sys_i) last <= dq_o;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick
   task automatic burst(input logic wr, input logic [15:0] a, input logic [1:0] be, input int lim,
                        output int first, output int cnt);
      first = -1;
      cnt = 0;
      drv <= 1'b1;
      dq_d <= a;
      pins_o <= {3'h0, 1'b1, ~wr, be};
      tick(HP);
      pins_o[P_CLK] <= 1'b1;
      tick(HP);
      pins_o <= {3'h1, wr, ~wr, be};
      drv <= wr;
      dq_d <= wq[0];
      // select stays low through latency; stop after lim clock rises
      for (int k = 1; k <= lim; k++) begin
         tick(HP);
         if (k == susp) begin
            // clock parked low, bus freed, oe back low before a read restarts
            pins_o[P_OE] <= 1'b1;
            tick(4 * HP);
            susp_oe = wait_oe_n_i;
            pins_o[P_OE] <= wr;
            tick(HP);
         end
         idle_w = (wait_i === ~wpol);
         pins_o[P_CLK] <= 1'b1;
         if (idle_w) begin
            if (first < 0) first = k;
            if (cnt < 16) rq[cnt] = dq_o;
            cnt++;
         end
         tick(HP);
         pins_o[P_CLK] <= 1'b0;
         dq_d <= wq[cnt % 16];
      end
      // deselect well inside the select low-time limit
      tick(HP);
      pins_o <= 7'h3F;
      drv <= 1'b0;
      tick(2 * HP);
   endtask : burst
   // clock parked low throughout; oe high while the address is out
   task automatic async_op(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
      drv <= 1'b1;
      dq_d <= a;
      pins_o <= {3'h0, 1'b1, ~wr, 2'h0};
      tick(HP);
      pins_o[P_ADV] <= 1'b1;
      tick(HP);
      drv <= wr;
      dq_d <= d;
      pins_o[P_OE] <= wr;
      tick(6 * HP);
      aoe = wait_oe_n_i;
      q = dq_o;
      pins_o[P_WE] <= 1'b1;
      tick(HP);
      pins_o <= 7'h3F;
      drv <= 1'b0;
      tick(2 * HP);
   endtask : async_op
endmodule : pbp_ctl_model
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench: burst and async traffic through the controller model
`timescale 1ns/1ns
`default_nettype none
module tb_top import pbp_pkg::*;;
   localparam int INIT_N = 20;
   typedef struct {logic [2:0] lat; logic wp, lt, nw; logic [2:0] bl; logic [15:0] a; logic [1:0] be; int l, n;} pbp_row_s;
   pbp_row_s rows[6] = '{'{3'h0, 1'b1, 1'b0, 1'b1, 3'h1, 16'h0010, 2'h0, 9, 4},
      '{3'h2, 1'b0, 1'b1, 1'b1, 3'h2, 16'h0020, 2'h0, 3, 8}, '{3'h6, 1'b1, 1'b0, 1'b0, 3'h3, 16'h0045, 2'h0, 7, 16},
      '{3'h3, 1'b0, 1'b0, 1'b1, 3'h7, 16'h007D, 2'h0, 4, 3}, '{3'h4, 1'b1, 1'b1, 1'b0, 3'h1, 16'h0012, 2'h2, 5, 4},
      '{3'h5, 1'b1, 1'b0, 1'b1, 3'h2, 16'h0020, 2'h1, 6, 8}};
   logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, refresh_req_i = 1'b0, cfg_write_i = 1'b0;
   logic [15:0] cfg_v = 16'h1D1F, mem_exp[4096], dq_w, dq_o_w, bcr_w, rcr_w;
   logic [6:0]  pins_w;
   logic [1:0]  oe_n_w;
   logic        wait_w, wait_oe_n_w, init_w, sb_w, lp_w;
   int          errors = 0, comparisons = 0, first, cnt;
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   pbp_top #(.INIT_CYCLES(INIT_N), .REFRESH_CYCLES(8'hC8)) pbp_top_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .en_i(1'b1), .mem_clk_i(pins_w[P_CLK]),
      .chip_select_n_i(pins_w[P_CE]), .address_valid_n_i(pins_w[P_ADV]), .output_enable_n_i(pins_w[P_OE]),
      .write_enable_n_i(pins_w[P_WE]), .upper_byte_enable_n_i(pins_w[P_UB]), .lower_byte_enable_n_i(pins_w[P_LB]),
      .muxed_addr_data_bus_i(dq_w), .addr_hi_i(5'h00), .muxed_addr_data_bus_o(dq_o_w),
      .muxed_addr_data_bus_oe_n_o(oe_n_w), .wait_o(wait_w), .wait_oe_n_o(wait_oe_n_w),
      .refresh_req_i(refresh_req_i), .cfg_write_i(cfg_write_i), .cfg_bus_config_i(cfg_v),
      .cfg_refresh_config_i(16'h0000), .bus_config_reg_o(bcr_w), .refresh_config_reg_o(rcr_w),
      .init_done_o(init_w), .standby_o(sb_w), .low_power_o(lp_w));
   pbp_ctl_model pbp_ctl_model_inst (.clk_sys_i(clk_sys_i), .wait_i(wait_w), .wait_oe_n_i(wait_oe_n_w),
      .dev_dq_i(dq_o_w), .dev_oe_n_i(oe_n_w), .pins_o(pins_w), .dq_o(dq_w));
   task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_val
   task automatic chk_num(input string nm, input int exp, input int got);
      comparisons++;
      if (got != exp) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_num
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic cfg(input logic [15:0] v);
      @(posedge clk_sys_i);
      cfg_v <= v;
      cfg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      cfg_write_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk_val("bus config", v, bcr_w);
      pbp_ctl_model_inst.wpol = v[BCR_WPOL_BIT];
   endtask : cfg
   // word address of beat i, wrapping inside the burst when asked to
   function automatic logic [15:0] ea(pbp_row_s w, int i);
      return w.nw ? w.a + 16'(i) : (w.a & ~16'(w.n - 1)) | ((w.a + 16'(i)) & 16'(w.n - 1));
   endfunction : ea
   initial begin
      pbp_row_s    w;
      logic [15:0] q, d;
      logic [11:0] e;
      repeat (8) @(posedge clk_sys_i);
      chk_val("bus drive in reset", 16'h0003, oe_n_w);
      chk_val("wait drive in reset", 16'h0001, wait_oe_n_w);
      sys_rst_i <= 1'b0;
      repeat (INIT_N - 2) @(posedge clk_sys_i);
      chk_val("init early", 16'h0000, init_w);
      repeat (4) @(posedge clk_sys_i);
      chk_val("init done", 16'h0001, init_w);
      chk_val("default config", BCR_DEFAULT, bcr_w);
      chk_val("default refresh config", RCR_DEFAULT, rcr_w);
      chk_val("standby", 16'h0001, sb_w);
      $display("test reset done");
      for (int r = 0; r < 6; r++) begin
         w = rows[r];
         cfg({1'b0, w.lt, w.lat, w.wp, 6'h11, w.nw, w.bl});
         pbp_ctl_model_inst.susp = (r == 2) ? 6 : 0;
         for (int i = 0; i < w.n; i++) begin
            e = 12'(ea(w, i));
            d = {4'(r + 1), e};
            pbp_ctl_model_inst.wq[i] = d;
            mem_exp[e] = {w.be[1] ? mem_exp[e][15:8] : d[15:8], w.be[0] ? mem_exp[e][7:0] : d[7:0]};
         end
         pbp_ctl_model_inst.burst(1'b1, w.a, w.be, w.l + w.n + 3, first, cnt);
         chk_num("write latency", w.l, first);
         chk_num("write words", w.n, cnt);
         pbp_ctl_model_inst.burst(1'b0, w.a, 2'h0, w.l + w.n + 3, first, cnt);
         chk_num("read latency", w.l, first);
         chk_num("read words", w.n, cnt);
         for (int i = 0; i < w.n; i++) begin
            chk_val("read data", mem_exp[12'(ea(w, i))], pbp_ctl_model_inst.rq[i]);
         end
         if (r == 2) chk_val("wait drive in suspend", 16'h0000, pbp_ctl_model_inst.susp_oe);
         chk_val("low power after burst", 16'h0001, lp_w);
         $display("test row %0d done", r);
      end
      for (int m = 0; m < 2; m++) begin
         cfg({m[0], 15'h1D1F});
         pbp_ctl_model_inst.async_op(1'b1, 16'h0300 + 16'(m), 16'hC0DE ^ 16'(m), q);
         chk_val("wait drive in async write", 16'h0001, pbp_ctl_model_inst.aoe);
         pbp_ctl_model_inst.async_op(1'b0, 16'h0300 + 16'(m), 16'h0000, q);
         chk_val("wait drive in async read", 16'h0000, pbp_ctl_model_inst.aoe);
         chk_val("async data", 16'hC0DE ^ 16'(m), q);
      end
      pbp_ctl_model_inst.burst(1'b0, 16'h0010, 2'h0, 12, first, cnt);
      chk_num("burst in async mode", 0, cnt);
      $display("test async done");
      // fixed latency first, then variable; refresh is raised mid-latency
      for (int v = 0; v < 2; v++) begin
         cfg({1'b0, ~v[0], 14'h1D1F});
         fork
            pbp_ctl_model_inst.burst(1'b0, 16'h0010, 2'h0, 40, first, cnt);
            begin
               repeat (10) @(posedge clk_sys_i);
               chk_val("low power in burst", 16'h0000, lp_w);
               refresh_req_i <= 1'b1;
               @(posedge clk_sys_i);
               refresh_req_i <= 1'b0;
            end
         join
         chk_num("refresh stretches latency", v, int'(first > 4));
         chk_val("data after refresh", mem_exp[12'h010], pbp_ctl_model_inst.rq[0]);
         repeat (250) @(posedge clk_sys_i);
      end
      $display("test refresh done");
      end_of_test();
   end
   // about ten times the expected run length
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      errors++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
